// ==== tb/ctx_properties.sv ====
// link assertions watching the host and radio ends of the test mode
module ctx_properties
(
   // clock and reset
   input wire logic       clk,
   input wire logic       resetn,
   // link
   input wire logic       req,
   input wire logic       we,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       ack,
   input wire logic [7:0] rdata,
   input wire logic       fb_we,
   input wire logic [6:0] fb_addr,
   input wire logic [7:0] fb_data,
   input wire logic       irq,
   input wire logic       radio_rst
);
   timeunit 1ns;
   timeprecision 1ns;
   import ctx_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   //==========================================
   // sequence history since the last radio reset
   typedef struct packed {
      logic en1;       // last enable write was the first key
      logic test_on;   // test code written
      logic raw;       // raw data mode written
      logic synth;     // synth on commanded
      logic lock_rd;   // lock seen in interrupt status
   } hist_t;
   hist_t h;           // history flags
   logic  wtake;       // write taken by the radio
   assign wtake = req & we & ~ack;
   // track host writes and the lock readback
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         h <= '0;
      else if (radio_rst)
         h <= '0;
      else
      begin
         if (wtake && addr == A_ENABLE)
            h.en1 <= (wdata == V_EN1);
         if (wtake && addr == A_TEST)
            h.test_on <= (wdata == V_TEST_ON);
         if (wtake && addr == A_RAW_A)
            h.raw <= (wdata == V_RAW_A);
         if (wtake && addr == A_CMD && wdata == C_SYNTH)
            h.synth <= 1'b1;
         if (ack && !we && addr == A_IRQ && rdata == V_LOCK)
            h.lock_rd <= 1'b1;
      end
   end
   //==========================================
   // link handshake
   req_hold_a: assert property (req && !ack |=> req && $stable({we, addr, wdata}))
      else $error("link request changed before its answer");
   ack_timing_a: assert property ($rose(req) |=> ack ##1 (!ack && !req))
      else $error("link answer not one cycle after take");
   rst_pulse_a: assert property (radio_rst |=> !radio_rst)
      else $error("radio reset longer than one cycle");
   //==========================================
   // programming order
   en_order_a: assert property (wtake && addr == A_ENABLE && wdata == V_EN2
      |-> h.en1 && h.test_on)
      else $error("second key without first key and test code");
   go_lock_a: assert property (wtake && addr == A_CMD && wdata == C_TX_GO |-> h.lock_rd)
      else $error("transmit command before lock was read");
   lock_irq_a: assert property ($rose(irq) |-> h.synth)
      else $error("interrupt without synth on command");
   len_byte_a: assert property (fb_we && fb_addr == 7'h00
      |-> fb_data != 8'h00 && !fb_data[7])
      else $error("length byte out of range");
   tone_bytes_a: assert property (fb_we && fb_addr != 7'h00 && h.raw
      |-> fb_data == B_LOW || fb_data == B_HIGH)
      else $error("tone payload byte not all zeros or ones");
endmodule : ctx_properties

// ==== tb/test_continuous_tx_test_mode.sv ====
// bench: host and radio ends joined by the link, driven over APB
module test_continuous_tx_test_mode;
   timeunit 1ns;
   timeprecision 1ns;
   import ctx_pkg::*;
   logic        clk, resetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr, tx_byte;
   logic [31:0] pwdata, prdata, q;
   logic        tx_on, tx_cw, tx_tone_up, tx_strobe;
   logic [11:0] e;             // {tone, on, cw, up, byte or buffer index}
   logic [7:0]  b;             // expected byte on air
   logic [7:0]  fbm [0:127];   // copy of what the host loaded
   logic [11:0] exp_q[$];      // expected per transmit strobe
   int          errors = 0;
   int          samples_checked = 0;
   //==========================================
   // clock, ends and checker
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   ctx_link_if link (.clk(clk));
   ctx_host u_ctx_host (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link));
   ctx_radio u_ctx_radio (.clk(clk), .resetn(resetn), .link(link), .tx_on(tx_on),
      .tx_cw(tx_cw), .tx_tone_up(tx_tone_up), .tx_byte(tx_byte), .tx_strobe(tx_strobe));
   ctx_properties u_ctx_properties (.clk(clk), .resetn(resetn), .req(link.req),
      .we(link.we), .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
      .rdata(link.rdata), .fb_we(link.fb_we), .fb_addr(link.fb_addr),
      .fb_data(link.fb_data), .irq(link.irq), .radio_rst(link.radio_rst));
   //==========================================
   // checks and closing
   task automatic check(input logic [31:0] got, input logic [31:0] want);
      samples_checked++;
      if (got !== want)
      begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask : check
   task automatic end_sim;
      $display("compares %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim
   task automatic give_up;
      errors++;
      $display("wait ran out at %0t", $time);
      end_sim();
   endtask : give_up
   // one APB transfer, then one idle cycle
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1)
         give_up();
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   //==========================================
   // buffer copy from the link
   always @(posedge clk)
      if (link.fb_we === 1'b1)
         fbm[link.fb_addr] <= link.fb_data;
   // transmit strobe monitor, modulated bytes against the loaded buffer
   always @(posedge clk)
      if (tx_strobe === 1'b1 && exp_q.size() > 0)
      begin
         e = exp_q.pop_front();
         b = e[11] ? e[7:0] : fbm[e[6:0]];
         check({20'h0, e[11], tx_on, tx_cw, tx_tone_up, tx_byte},
            {20'h0, e[11:9], e[11] ? e[8] : b[7], b});
      end
   // one test run: configure, start, watch repeats, stop
   task automatic run(input logic tone, input logic hi);
      int len;
      int n;
      len = 1 + $urandom % 6;
      apb(1'b1, P_CONFIG, {6'h0, 2'($urandom), 1'b0, 7'(len), 8'($urandom), 8'($urandom)});
      for (n = 0; n < len + 2; n++)
         exp_q.push_back({tone, 1'b1, tone, tone & hi,
            tone ? {8{hi}} : {1'b0, 7'(n % len + 1)}});
      apb(1'b1, P_CTRL, {28'h0, 1'b0, hi, tone, 1'b1});
      for (n = 0; n < 20000 && exp_q.size() != 0; n++)
         @(posedge clk);
      if (exp_q.size() != 0)
         give_up();
      check(32'(fbm[0]), 32'(len));
      apb(1'b0, P_STATUS, 32'h0);
      check(32'(q[11:8]), 32'h3);
      apb(1'b1, P_CTRL, 32'h8);
      for (n = 0; n < 100 && q[11] !== 1'b1; n++)
         apb(1'b0, P_STATUS, 32'h0);
      check(32'(q[11:8]), 32'h9);
      check(32'(tx_on), 32'h0);
      $display("run done: tone %0d high %0d length %0d", tone, hi, len);
   endtask : run
   //==========================================
   // main sequence
   initial
   begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      void'($urandom(62232));
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      apb(1'b0, P_CONFIG, 32'h0);
      check(q, R_CONFIG);
      apb(1'b0, P_STATUS, 32'h0);
      check(q, 32'h0);
      apb(1'b0, 8'h0c, 32'h0);
      check({31'h0, err}, 32'h1);
      check(q, 32'h0);
      $display("register test done");
      run(1'b1, 1'b0);
      run(1'b1, 1'b1);
      run(1'b0, 1'b0);
      end_sim();
   end
endmodule : test_continuous_tx_test_mode

// ==== verilog/ctx_host.sv ====
// host end: APB registers and the test-mode programming sequence
//
// The implementer's own choice: the APB slave port.
module ctx_host
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // link
   ctx_link_if.host         link
);
   import ctx_pkg::*;
   //==========================================
   // step kinds
   typedef enum logic [2:0] {K_RST, K_WR, K_RD, K_FB, K_IRQ, K_MEAS} kind_t;
   typedef enum logic [2:0] {H_IDLE = 3'b000, H_ISSUE = 3'b001, H_WAIT = 3'b011,
                             H_FB = 3'b010, H_IRQ = 3'b110, H_MEAS = 3'b111,
                             H_DONE = 3'b101, H_ERR = 3'b100} hstate_t;
   typedef struct packed {
      hstate_t     st;
      logic [4:0]  step;       // 0..19
      logic        cw, high, stop;
      logic [31:0] cfg;
      logic [6:0]  fbi;        // buffer index
      logic [7:0]  lfsr;       // random payload
      logic        req, we, fb_we, rst;
      logic [7:0]  addr, wdata, expect_v;
      logic        expect_en;
      logic [6:0]  fb_addr;
      logic [7:0]  fb_data;
      logic [31:0] prdata;
      logic        pready, pslverr;
   } host_t;
   host_t h, next_h;
   kind_t      k;
   logic [7:0] sa, sd;
   logic       skip;
   logic [6:0] len;
   //==========================================
   // sequence table: kind, address, data
   function automatic kind_t step_kind(input logic [4:0] s);
      case (s)
         5'd0, 5'd19: return K_RST;
         5'd7:        return K_RD;
         5'd11:       return K_FB;
         5'd15:       return K_IRQ;
         5'd17:       return K_MEAS;
         default:     return K_WR;
      endcase
   endfunction : step_kind
   function automatic logic [15:0] step_ad(input logic [4:0] s, input logic [31:0] c);
      case (s)
         5'd1:    return {A_MASK, V_LOCK};
         5'd2:    return {A_CRC, 8'h00};
         5'd3:    return {A_CMD, C_IDLE};
         5'd4:    return {A_CLKOUT, V_CLKOUT};
         5'd5:    return {A_CHAN, c[7:0]};
         5'd6:    return {A_POWER, c[15:8]};
         5'd7:    return {A_STATUS, C_IDLE_ST};
         5'd8:    return {A_TEST, V_TEST_ON};
         5'd9:    return {A_RAW_A, V_RAW_A};
         5'd10:   return {A_RAW_B, V_RAW_B};
         5'd12:   return {A_ENABLE, V_EN1};
         5'd13:   return {A_ENABLE, V_EN2};
         5'd14:   return {A_CMD, C_SYNTH};
         5'd15:   return {A_IRQ, V_LOCK};
         5'd16:   return {A_CMD, C_TX_GO};
         5'd18:   return {A_ENABLE, 8'h00};
         default: return 16'h0000;
      endcase
   endfunction : step_ad
   //==========================================
   // next state
   always_comb
   begin
      next_h         = h;
      k              = step_kind(h.step);
      {sa, sd}       = step_ad(h.step, h.cfg);
      len            = (h.cfg[CF_LEN +: 7] == 7'h00) ? 7'h01 : h.cfg[CF_LEN +: 7];
      // optional settings and tone-only writes are skipped
      skip           = (h.step == 5'd5 && !h.cfg[CF_SCH])
                    || (h.step == 5'd6 && !h.cfg[CF_SPW])
                    || ((h.step == 5'd9 || h.step == 5'd10) && !h.cw);
      next_h.fb_we   = 1'b0;
      next_h.rst     = 1'b0;
      next_h.pready  = 1'b0;
      next_h.pslverr = 1'b0;
      // APB setup cycle prepares the answer for the access cycle
      if (psel && !penable)
      begin
         next_h.pready = 1'b1;
         next_h.prdata = 32'h0000_0000;
         case (paddr)
            P_CTRL:   next_h.prdata = {28'h0, h.stop, h.high, h.cw, 1'b0};
            P_CONFIG: next_h.prdata = h.cfg;
            P_STATUS: next_h.prdata = {20'h0, h.st == H_DONE, h.st == H_ERR,
                                       h.st == H_MEAS, h.st != H_IDLE, 3'h0, h.step};
            default:  next_h.pslverr = 1'b1;
         endcase
      end
      // writes land only at the edge where the master sees pready high
      if (psel && penable && h.pready && pwrite)
      begin
         case (paddr)
            P_CTRL:
            begin
               next_h.stop = pwdata[3];
               if (pwdata[0] && (h.st == H_IDLE || h.st == H_DONE || h.st == H_ERR))
               begin
                  next_h.cw   = pwdata[1];
                  next_h.high = pwdata[2];
                  next_h.step = 5'd0;
                  next_h.st   = H_ISSUE;
               end
            end
            P_CONFIG:
            begin
               if (h.st == H_IDLE || h.st == H_DONE || h.st == H_ERR)
                  next_h.cfg = pwdata;
            end
            default: ;
         endcase
      end
      case (h.st)
         H_ISSUE:
         begin
            // dispatch the current step
            if (skip)
               next_h.step = h.step + 5'd1;
            else
            case (k)
               K_RST:
               begin
                  next_h.rst  = 1'b1;
                  next_h.step = h.step + 5'd1;
                  if (h.step == 5'd19)
                     next_h.st = H_DONE;
               end
               K_FB:
               begin
                  next_h.st  = H_FB;
                  next_h.fbi = 7'h00;
               end
               K_IRQ:    next_h.st = H_IRQ;
               K_MEAS:   next_h.st = H_MEAS;
               default:
               begin
                  next_h.req       = 1'b1;
                  next_h.we        = (k == K_WR);
                  next_h.addr      = sa;
                  next_h.wdata     = sd;
                  next_h.expect_en = (k == K_RD);
                  next_h.expect_v  = sd;
                  next_h.st        = H_WAIT;
               end
            endcase
         end
         H_WAIT:
         begin
            // hold the access until the radio answers
            if (link.ack)
            begin
               next_h.req  = 1'b0;
               next_h.step = h.step + 5'd1;
               next_h.st   = (h.expect_en && link.rdata != h.expect_v) ? H_ERR : H_ISSUE;
            end
         end
         H_FB:
         begin
            // length byte then payload, one byte a cycle
            next_h.fb_we   = 1'b1;
            next_h.fb_addr = h.fbi;
            if (h.fbi == 7'h00)
               next_h.fb_data = {1'b0, len};
            else if (h.cw)
               next_h.fb_data = h.high ? B_HIGH : B_LOW;
            else
            begin
               next_h.fb_data = h.lfsr;
               next_h.lfsr    = {h.lfsr[6:0], h.lfsr[7] ^ h.lfsr[5] ^ h.lfsr[4] ^ h.lfsr[3]};
            end
            next_h.fbi = h.fbi + 7'h01;
            if (h.fbi == len)
            begin
               next_h.st   = H_ISSUE;
               next_h.step = h.step + 5'd1;
            end
         end
         H_IRQ:
         begin
            // lock interrupt, then confirm by reading interrupt status
            if (link.irq)
            begin
               next_h.req       = 1'b1;
               next_h.we        = 1'b0;
               next_h.addr      = sa;
               next_h.expect_en = 1'b1;
               next_h.expect_v  = sd;
               next_h.st        = H_WAIT;
            end
         end
         H_MEAS:
         begin
            // transmit runs until software asks to stop
            if (h.stop)
            begin
               next_h.stop = 1'b0;
               next_h.step = h.step + 5'd1;
               next_h.st   = H_ISSUE;
            end
         end
         default: ;
      endcase
   end
   //==========================================
   // state register
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         h      <= '0;
         h.cfg  <= R_CONFIG;
         h.lfsr <= 8'h01;
      end
      else
         h <= next_h;
   end
   assign prdata         = h.prdata;
   assign pready         = h.pready;
   assign pslverr        = h.pslverr;
   assign link.req       = h.req;
   assign link.we        = h.we;
   assign link.addr      = h.addr;
   assign link.wdata     = h.wdata;
   assign link.fb_we     = h.fb_we;
   assign link.fb_addr   = h.fb_addr;
   assign link.fb_data   = h.fb_data;
   assign link.radio_rst = h.rst;
endmodule : ctx_host

// ==== verilog/ctx_link_if.sv ====
// link between host sequencer and test-mode radio
interface ctx_link_if (input wire logic clk);
   logic       req;         // register access held until ack
   logic       we;          // write when high
   logic [7:0] addr;        // register address
   logic [7:0] wdata;       // write data
   logic       ack;         // one-cycle answer
   logic [7:0] rdata;       // read data valid with ack
   logic       fb_we;       // frame buffer byte strobe
   logic [6:0] fb_addr;     // buffer index, 0 is length
   logic [7:0] fb_data;     // buffer byte
   logic       irq;         // interrupt level
   logic       radio_rst;   // radio soft reset, high active
   modport radio (input req, we, addr, wdata, fb_we, fb_addr, fb_data, radio_rst,
                  output ack, rdata, irq);
   modport host  (output req, we, addr, wdata, fb_we, fb_addr, fb_data, radio_rst,
                  input ack, rdata, irq);
endinterface : ctx_link_if

// ==== verilog/ctx_pkg.sv ====
// constants shared by the test-mode radio end and the host sequencer end
//==========================================
// Contract
// - test mode sends frame or tone without break
// - tone sits half a megahertz off centre
// - no tone exactly on channel centre
// - headers omitted, PSDU repeats from first byte
// - host loads at least a length byte
// - host should load maximum length frame; the host loads the P_CONFIG length, 127 at reset
// - host configures before enabling test mode
// - enable needs test control and second register
// - host commands synth on, then transmit
// - buffer load needed in tone mode too
// - host unmasks lock irq, disables checksum
// - host commands idle, checks status 0x08
// - host may set channel and power
// - code 0xF enables, 0x0 none, rest reserved
// - tone mode only: raw data writes
// - host writes 0x54 then 0x46
// - synth on, lock irq, then transmit
// - bytes 0x00 low tone, 0xFF high tone
// - random maximum payload for spectral mask; the host sends a random payload of the P_CONFIG length
package ctx_pkg;
   //==========================================
   // radio register addresses
   localparam logic [7:0] A_STATUS  = 8'h01;   // radio state readback
   localparam logic [7:0] A_CMD     = 8'h02;   // radio_state_command
   localparam logic [7:0] A_CLKOUT  = 8'h03;   // clock_output_pin control
   localparam logic [7:0] A_CRC     = 8'h04;   // checksum append control
   localparam logic [7:0] A_POWER   = 8'h05;   // output power
   localparam logic [7:0] A_CHAN    = 8'h08;   // channel
   localparam logic [7:0] A_RAW_B   = 8'h0a;   // raw data mode, second
   localparam logic [7:0] A_RAW_A   = 8'h0c;   // raw data mode, first
   localparam logic [7:0] A_MASK    = 8'h0e;   // interrupt mask
   localparam logic [7:0] A_IRQ     = 8'h0f;   // interrupt status
   localparam logic [7:0] A_ENABLE  = 8'h1c;   // second enabling register
   localparam logic [7:0] A_TEST    = 8'h36;   // tx_test_control
   //==========================================
   // values
   localparam logic [7:0] C_TX_GO   = 8'h02;   // transmit command / busy code
   localparam logic [7:0] C_IDLE    = 8'h03;   // radio_idle_state command
   localparam logic [7:0] C_IDLE_ST = 8'h08;   // radio_idle_state status
   localparam logic [7:0] C_SYNTH   = 8'h09;   // synth on command / status
   localparam logic [7:0] V_LOCK    = 8'h01;   // lock interrupt bit
   localparam logic [7:0] V_CLKOUT  = 8'h01;
   localparam logic [7:0] V_RAW_A   = 8'h03;
   localparam logic [7:0] V_RAW_B   = 8'h37;
   localparam logic [7:0] V_EN1     = 8'h54;
   localparam logic [7:0] V_EN2     = 8'h46;
   localparam logic [7:0] V_TEST_ON = 8'h0f;
   localparam logic [3:0] F_CONT    = 4'hf;    // tx_test_function_code: on
   localparam logic [3:0] F_NONE    = 4'h0;    // tx_test_function_code: off
   localparam logic [7:0] R_TEST    = 8'h00;   // test control reset value
   localparam logic [7:0] B_LOW     = 8'h00;   // payload byte, tone below
   localparam logic [7:0] B_HIGH    = 8'hff;   // payload byte, tone above
   localparam logic [6:0] MAX_LEN   = 7'h7f;   // longest PSDU
   //==========================================
   // timing at 25 MHz
   localparam int CLK_NS   = 40;
   localparam int BYTE_NS  = 32000;            // one PSDU byte on air
   localparam int LOCK_NS  = 80000;            // synthesizer settle
   localparam int BYTE_CYC = BYTE_NS / CLK_NS;
   localparam int LOCK_CYC = (LOCK_NS + CLK_NS - 1) / CLK_NS;
   //==========================================
   // host APB registers
   localparam logic [7:0] P_CTRL   = 8'h00;    // [0]start [1]tone [2]high [3]stop
   localparam logic [7:0] P_CONFIG = 8'h04;    // chan, power, len, set bits
   localparam logic [7:0] P_STATUS = 8'h08;    // step, busy, tx, error, done
   localparam int CF_POW = 8;
   localparam int CF_LEN = 16;
   localparam int CF_SCH = 24;
   localparam int CF_SPW = 25;
   localparam logic [31:0] R_CONFIG = 32'h007f_0000;
endpackage : ctx_pkg

// ==== verilog/ctx_radio.sv ====
// test-mode radio end: registers, frame buffer, continuous transmitter
module ctx_radio
(
   // clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // link
   ctx_link_if.radio link,
   // transmitter drive
   output logic       tx_on,
   output logic       tx_cw,
   output logic       tx_tone_up,
   output logic [7:0] tx_byte,
   output logic       tx_strobe
);
   import ctx_pkg::*;
   //==========================================
   // state
   typedef enum logic [1:0] {S_OFF = 2'b00, S_PLL = 2'b01, S_LOCK = 2'b11,
                             S_TX = 2'b10} rstate_t;
   typedef struct packed {
      rstate_t     st;        // radio state
      logic [11:0] cnt;       // lock or byte timer
      logic [6:0]  idx;       // PSDU index
      logic [7:0]  mask, crc, chan, power, clko, raw_a, raw_b, test;
      logic [1:0]  en_step;   // second register sequence
      logic [7:0]  irqs;      // sticky interrupt status
      logic        ack;
      logic [7:0]  rdata;
      logic        irq, on, cw, up, strobe;
      logic [7:0]  byte_out;
   } radio_t;
   radio_t r, next_r;
   logic [7:0] fb [0:127];    // frame buffer
   logic       take;          // new access this cycle
   logic       armed;         // test mode fully enabled
   logic [7:0] cur;           // current PSDU byte
   logic [6:0] last;          // last PSDU index
   //==========================================
   // register readback
   function automatic logic [7:0] rd_mux(input radio_t s, input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         A_STATUS: v = (s.st == S_OFF) ? C_IDLE_ST : (s.st == S_TX) ? C_TX_GO : C_SYNTH;
         A_CLKOUT: v = s.clko;
         A_CRC:    v = s.crc;
         A_POWER:  v = s.power;
         A_CHAN:   v = s.chan;
         A_RAW_A:  v = s.raw_a;
         A_RAW_B:  v = s.raw_b;
         A_MASK:   v = s.mask;
         A_IRQ:    v = s.irqs;
         A_TEST:   v = s.test;
         default:  v = 8'h00;
      endcase
      return v;
   endfunction : rd_mux
   //==========================================
   // frame buffer write port
   always_ff @(posedge clk)
   begin
      if (link.fb_we)
      begin
         fb[link.fb_addr] <= link.fb_data;
      end
   end
   //==========================================
   // next state
   always_comb
   begin
      next_r = r;
      take   = link.req && !r.ack;
      armed  = (r.test[3:0] == F_CONT) && (r.en_step == 2'd2);
      last   = (fb[0][6:0] == 7'h00) ? 7'h01 : fb[0][6:0];
      cur    = fb[r.idx];
      next_r.ack    = take;
      next_r.strobe = 1'b0;
      if (take)
      begin
         next_r.rdata = rd_mux(r, link.addr);
         if (!link.we && link.addr == A_IRQ)
         begin
            next_r.irqs = 8'h00;                      // read clears
         end
         if (link.we)
         begin
            case (link.addr)
               A_CLKOUT: next_r.clko  = link.wdata;
               A_CRC:    next_r.crc   = link.wdata;
               A_POWER:  next_r.power = link.wdata;
               A_CHAN:   next_r.chan  = link.wdata;
               A_RAW_A:  next_r.raw_a = link.wdata;
               A_RAW_B:  next_r.raw_b = link.wdata;
               A_MASK:   next_r.mask  = link.wdata;
               A_TEST:   next_r.test  = link.wdata;
               A_ENABLE:
               begin
                  // 0x54 then 0x46 arms, anything else drops
                  if (link.wdata == V_EN1 && r.test[3:0] == F_CONT)
                     next_r.en_step = 2'd1;
                  else if (link.wdata == V_EN2 && r.en_step == 2'd1)
                     next_r.en_step = 2'd2;
                  else
                     next_r.en_step = 2'd0;
               end
               A_CMD:
               begin
                  if (link.wdata == C_IDLE)
                     next_r.st = S_OFF;
                  else if (link.wdata == C_SYNTH && r.st == S_OFF)
                  begin
                     next_r.st  = S_PLL;
                     next_r.cnt = 12'h000;
                  end
                  else if (link.wdata == C_TX_GO && r.st == S_LOCK && armed)
                  begin
                     next_r.st  = S_TX;
                     next_r.idx = 7'h01;
                     next_r.cnt = 12'(BYTE_CYC - 1);
                  end
               end
               default: ;
            endcase
         end
      end
      case (r.st)
         S_PLL:
         begin
            // synthesizer settle then lock event
            next_r.cnt = r.cnt + 12'h001;
            if (r.cnt == 12'(LOCK_CYC - 1))
            begin
               next_r.st   = S_LOCK;
               next_r.irqs = next_r.irqs | V_LOCK;    // set wins over read clear
            end
         end
         S_TX:
         begin
            // one byte per byte time, wrap to first PSDU byte
            if (!armed)
               next_r.st = S_LOCK;                    // enable cleared stops it
            else if (r.cnt == 12'(BYTE_CYC - 1))
            begin
               next_r.cnt      = 12'h000;
               next_r.strobe   = 1'b1;
               next_r.byte_out = cur;
               next_r.up       = cur[7];
               next_r.idx      = (r.idx >= last) ? 7'h01 : r.idx + 7'h01;
            end
            else
               next_r.cnt = r.cnt + 12'h001;
         end
         default: ;
      endcase
      next_r.on  = (next_r.st == S_TX);
      next_r.cw  = (r.raw_a == V_RAW_A) && (r.raw_b == V_RAW_B);
      next_r.irq = |(next_r.irqs & r.mask);
      if (link.radio_rst)
      begin
         next_r      = '0;
         next_r.test = R_TEST;
      end
   end
   //==========================================
   // state register
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         r <= '0;
      else
         r <= next_r;
   end
   assign link.ack   = r.ack;
   assign link.rdata = r.rdata;
   assign link.irq   = r.irq;
   assign tx_on      = r.on;
   assign tx_cw      = r.cw;
   assign tx_tone_up = r.up;
   assign tx_byte    = r.byte_out;
   assign tx_strobe  = r.strobe;
endmodule : ctx_radio
